/* File: bench/mstwd_chk.sv */
// assertion checker for the watchdog top ports
`timescale 1ns/1ps
module mstwd_chk (
  // clock and reset
  input wire logic                         sys_clk,
  input wire logic                         arst_n,
  // register bus
  input wire mstwd_pkg::mstwd_av_req_t     av_req,
  input wire mstwd_pkg::mstwd_av_rsp_t     av_rsp,
  // power pin and outputs
  input wire logic                         full_power_state,
  input wire logic                         sys_reset_req,
  input wire logic                         ms_tick,
  input wire logic [mstwd_pkg::FREQ_W-1:0] osc_mhz,
  input wire logic                         wdt_running
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire logic [7:0]  idx = av_req.address[9:2];
  wire logic [31:0] wd  = av_req.writedata;
  wire logic [6:0]  wd7 = av_req.writedata[6:0];
  wire logic        acw = av_req.write && !av_rsp.waitrequest;
  wire logic        fok = wd >= mstwd_pkg::FREQ_MIN && wd <= mstwd_pkg::FREQ_MAX;
  wire logic        fw  = acw && idx == mstwd_pkg::IDX_OSC_MHZ;
  wire logic        tw  = acw && idx == mstwd_pkg::IDX_WDT_TO;
  wire logic        tok = wd[31:16] == ~wd[15:0];
  wire logic        mw  = acw && idx == mstwd_pkg::IDX_WDT_KEY && wd == mstwd_pkg::KEY_MAGIC;
  sequence s_taken;
    (av_req.read || av_req.write) && av_rsp.waitrequest && $past(av_rsp.waitrequest);
  endsequence
  sequence s_ack;
    !av_rsp.waitrequest ##1 av_rsp.waitrequest;
  endsequence
  property p_take; s_taken |=> s_ack; endproperty
  property p_wrv; av_rsp.writeresponsevalid |-> !av_rsp.waitrequest && av_req.write; endproperty
  property p_freq_ok;
    fw && fok |-> av_rsp.response == mstwd_pkg::RSP_OKAY ##1 osc_mhz == $past(wd7);
  endproperty
  property p_freq_bad;
    fw && !fok |-> av_rsp.response == mstwd_pkg::RSP_SLVERR ##1 $stable(osc_mhz);
  endproperty
  property p_to_chk;
    tw |-> av_rsp.response == (tok ? mstwd_pkg::RSP_OKAY : mstwd_pkg::RSP_SLVERR);
  endproperty
  property p_magic; mw |-> ##[1:2] !wdt_running; endproperty
  property p_rst_hold; sys_reset_req |=> sys_reset_req; endproperty
  property p_rst_cause; $rose(sys_reset_req) |-> $past(wdt_running) ##1 !wdt_running; endproperty
  property p_tick; ms_tick |=> !ms_tick [*8]; endproperty
  property p_sleep; !$past(full_power_state, 3) |-> !$rose(sys_reset_req); endproperty
  a_take: assert property (p_take) else $error("request not answered after one wait");
  a_wrv: assert property (p_wrv) else $error("write response valid outside a write ack");
  a_freq_ok: assert property (p_freq_ok) else $error("valid frequency not stored");
  a_freq_bad: assert property (p_freq_bad) else $error("bad frequency accepted");
  a_to_chk: assert property (p_to_chk) else $error("timeout word check wrong");
  a_magic: assert property (p_magic) else $error("magic key did not disable");
  a_rst_hold: assert property (p_rst_hold) else $error("reset request dropped");
  a_rst_cause: assert property (p_rst_cause) else $error("reset request without expiry");
  a_tick: assert property (p_tick) else $error("tick pulse too long or too close");
  a_sleep: assert property (p_sleep) else $error("reset request rose while asleep");
endmodule

bind mstwd_top mstwd_chk mstwd_chk_i (
  .sys_clk          (sys_clk),
  .arst_n           (arst_n),
  .av_req           (av_req),
  .av_rsp           (av_rsp),
  .full_power_state (full_power_state),
  .sys_reset_req    (sys_reset_req),
  .ms_tick          (ms_tick),
  .osc_mhz          (osc_mhz),
  .wdt_running      (wdt_running)
);

/* File: bench/tb_top.sv */
// self-checking bench for the watchdog top
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic                     sys_clk, arst_n, full_power_state, sys_reset_req, ms_tick, wdt_running;
  logic [6:0]               osc_mhz;
  mstwd_pkg::mstwd_av_req_t av_req;
  mstwd_pkg::mstwd_av_rsp_t av_rsp;
  int                       n_fail = 0, tests_run = 0, cyc = 0;
  logic [31:0]              rd;
  logic [1:0]               rs;
  logic                     rv;

  mstwd_top mstwd_top_i (.sys_clk(sys_clk), .arst_n(arst_n), .av_req(av_req), .av_rsp(av_rsp),
    .full_power_state(full_power_state), .sys_reset_req(sys_reset_req), .ms_tick(ms_tick),
    .osc_mhz(osc_mhz), .wdt_running(wdt_running));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      tally_and_finish;
    end
  end

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] ix, input logic [31:0] d);
    av_req <= '{read: !w, write: w, address: {ix, 2'b00}, writedata: d};
    do @(posedge sys_clk); while (av_rsp.waitrequest !== 1'b0);
    rd = av_rsp.readdata;
    rs = av_rsp.response;
    rv = av_rsp.writeresponsevalid;
    av_req <= '0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] ix, input logic [31:0] d, input logic ok);
    bus(1'b1, ix, d);
    `CHK("write response", ok ? mstwd_pkg::RSP_OKAY : mstwd_pkg::RSP_SLVERR, rs)
    `CHK("write response valid", 1'b1, rv)
  endtask
  task automatic rdc(input logic [7:0] ix, input logic [31:0] e);
    bus(1'b0, ix, 32'h0000_0000);
    `CHK("read data", e, rd)
    `CHK("read response", 3'b000, {rv, rs})
  endtask
  task automatic period(input int e);
    int n = 0;
    do @(posedge sys_clk); while (ms_tick !== 1'b1);
    do begin
      @(posedge sys_clk);
      n++;
    end while (ms_tick !== 1'b1);
    `CHK("tick period", e, n)
  endtask

  task automatic t_reset;
    `CHK("osc_mhz", 7'h19, osc_mhz)
    `CHK("running", 1'b0, wdt_running)
    rdc(mstwd_pkg::IDX_OSC_MHZ, 32'h0000_0019);
    rdc(mstwd_pkg::IDX_WDT_TO, 32'h0000_03e8);
    rdc(mstwd_pkg::IDX_WDT_KEY, mstwd_pkg::KEY_MAGIC);
    bus(1'b0, 8'h00, 32'h0000_0000);
    `CHK("unmapped read", {mstwd_pkg::RSP_DECERR, 32'h0000_0000}, {rs, rd})
    $display("reset values done");
  endtask

  task automatic t_freq;
    logic [31:0] v [5] = '{32'h0000_0004, 32'h0000_0005, 32'h0000_0065, 32'h0000_0064,
                           32'h0000_0105};
    logic [6:0]  f = 7'h19;
    logic        ok;
    for (int i = 0; i < 5; i++) begin
      ok = v[i] >= mstwd_pkg::FREQ_MIN && v[i] <= mstwd_pkg::FREQ_MAX;
      wr(mstwd_pkg::IDX_OSC_MHZ, v[i], ok);
      if (ok) f = v[i][6:0];
      rdc(mstwd_pkg::IDX_OSC_MHZ, {25'h000_0000, f});
    end
    rdc(mstwd_pkg::IDX_WDT_STS, 32'h0000_000a);
    wr(mstwd_pkg::IDX_WDT_STS, 32'h0000_0002, 1'b1);
    rdc(mstwd_pkg::IDX_WDT_STS, 32'h0000_0008);
    wr(mstwd_pkg::IDX_OSC_MHZ, 32'h0000_0005, 1'b1);
    $display("frequency range done");
  endtask

  task automatic t_tick;
    period(5000);
    wr(mstwd_pkg::IDX_OSC_MHZ, 32'h0000_0006, 1'b1);
    period(6000);
    wr(mstwd_pkg::IDX_OSC_MHZ, 32'h0000_0005, 1'b1);
    $display("tick divider done");
  endtask

  task automatic t_sleep;
    full_power_state <= 1'b0;
    wr(mstwd_pkg::IDX_WDT_TO, 32'hfffe_0001, 1'b1);
    wr(mstwd_pkg::IDX_WDT_KEY, mstwd_pkg::KEY_ENABLE, 1'b1);
    repeat (11000) @(posedge sys_clk);
    `CHK("asleep no expiry", 1'b0, sys_reset_req)
    rdc(mstwd_pkg::IDX_WDT_TO, 32'h0001_0001);
    wr(mstwd_pkg::IDX_WDT_TO, 32'h0000_0002, 1'b0);
    wr(mstwd_pkg::IDX_WDT_KEY, mstwd_pkg::KEY_MAGIC, 1'b1);
    @(posedge sys_clk);
    `CHK("running", 1'b0, wdt_running)
    rdc(mstwd_pkg::IDX_WDT_TO, 32'h0000_0001);
    full_power_state <= 1'b1;
    repeat (11000) @(posedge sys_clk);
    `CHK("disabled no expiry", 1'b0, sys_reset_req)
    $display("power state and disable done");
  endtask

  task automatic t_expire;
    int n = 0;
    wr(mstwd_pkg::IDX_WDT_TO, 32'hfffd_0002, 1'b1);
    wr(mstwd_pkg::IDX_WDT_KEY, mstwd_pkg::KEY_ENABLE, 1'b1);
    @(posedge sys_clk);
    `CHK("running", 1'b1, wdt_running)
    // align to a tick so no decrement lands inside the refresh reads
    do @(posedge sys_clk); while (ms_tick !== 1'b1);
    rdc(mstwd_pkg::IDX_WDT_TO, 32'h0001_0002);
    wr(mstwd_pkg::IDX_WDT_TO, 32'hfffd_0002, 1'b1);
    rdc(mstwd_pkg::IDX_WDT_TO, 32'h0002_0002);
    while (sys_reset_req !== 1'b1) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK("expiry window", 1'b1, n > 4990 && n <= 10010)
    rdc(mstwd_pkg::IDX_WDT_TO, 32'h0000_0002);
    repeat (100) @(posedge sys_clk);
    `CHK("request held", 2'b10, {sys_reset_req, wdt_running})
    arst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    `CHK("cleared by reset", 9'h019, {sys_reset_req, wdt_running, osc_mhz})
    rdc(mstwd_pkg::IDX_WDT_TO, 32'h0000_03e8);
    rdc(mstwd_pkg::IDX_WDT_KEY, mstwd_pkg::KEY_MAGIC);
    $display("expiry and refresh done");
  endtask

  initial begin
    arst_n = 1'b0;
    full_power_state = 1'b1;
    av_req = '0;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset;
    t_freq;
    t_tick;
    t_sleep;
    t_expire;
    tally_and_finish;
  end
endmodule

/* File: include/mstwd_pkg.sv */
// constants and carrier types for the millisecond-tick watchdog
package mstwd_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W  = 8;
  localparam int unsigned IDX_LSB = 2;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_OSC_MHZ = 8'h51;
  localparam logic [IDX_W-1:0] IDX_WDT_TO  = 8'hd6;
  localparam logic [IDX_W-1:0] IDX_WDT_KEY = 8'hd7;
  localparam logic [IDX_W-1:0] IDX_WDT_STS = 8'hd8;

  // frequency field
  localparam int unsigned FREQ_W = 7;
  localparam logic [FREQ_W-1:0] FREQ_RST = 7'h19;
  localparam logic [DATA_W-1:0] FREQ_MIN = 32'h0000_0005;
  localparam logic [DATA_W-1:0] FREQ_MAX = 32'h0000_0064;

  // timeout word layout
  localparam int unsigned HALF_W  = 16;
  localparam int unsigned CNT_LSB = 16;
  localparam logic [HALF_W-1:0] TIMEOUT_RST = 16'h03e8;
  localparam logic [HALF_W-1:0] CNT_RST     = 16'h0000;
  localparam logic [HALF_W-1:0] CNT_ONE     = 16'h0001;

  // disable key values
  localparam logic [DATA_W-1:0] KEY_MAGIC  = 32'h0d15_ab1e;
  localparam logic [DATA_W-1:0] KEY_ENABLE = 32'h0000_0000;

  // status bit positions
  localparam int unsigned STS_EXPIRED = 0;
  localparam int unsigned STS_NACK    = 1;
  localparam int unsigned STS_RUN     = 2;
  localparam int unsigned STS_FULL_POWER_STATE   = 3;

  // avalon response codes
  localparam logic [1:0] RSP_OKAY   = 2'b00;
  localparam logic [1:0] RSP_SLVERR = 2'b10;
  localparam logic [1:0] RSP_DECERR = 2'b11;

  // tick timing: one tick per millisecond, i.e. mhz times this many cycles
  localparam int unsigned TICK_PERIOD_US = 1000;
  localparam int unsigned DIV_W          = 17;

  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } mstwd_bus_st_t;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
  } mstwd_av_req_t;

  typedef struct packed {
    logic              waitrequest;
    logic [DATA_W-1:0] readdata;
    logic [1:0]        response;
    logic              writeresponsevalid;
  } mstwd_av_rsp_t;

endpackage

/* File: logic/mstwd_tick_div.sv */
// millisecond tick divider driven by the programmed oscillator frequency
`timescale 1ns/1ps
module mstwd_tick_div (
  // clock and reset
  input  wire logic                             sys_clk,
  input  wire logic                             arst_n,
  // programmed frequency in mhz
  input  wire logic [mstwd_pkg::FREQ_W-1:0]     mhz,
  // one-cycle tick
  output logic                                  tick
);

  logic [mstwd_pkg::DIV_W-1:0] div_r;
  logic [mstwd_pkg::DIV_W-1:0] div_nxt;
  logic [mstwd_pkg::DIV_W-1:0] limit;
  logic                        wrap;

  // period is mhz * 1000 cycles, derived from the live setting
  assign limit   = mstwd_pkg::DIV_W'(32'(mhz) * mstwd_pkg::TICK_PERIOD_US - 1);
  // wrap also catches a count left above a newly lowered limit
  assign wrap    = (div_r >= limit);
  assign div_nxt = wrap ? '0 : div_r + mstwd_pkg::DIV_W'(1);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_r <= '0;
      tick  <= 1'b0;
    end else begin
      div_r <= div_nxt;
      tick  <= wrap;
    end
  end

endmodule

/* File: logic/mstwd_top.sv */
// millisecond-tick watchdog with oscillator frequency setting and avalon slave
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module mstwd_top (
  // clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           arst_n,
  // avalon-mm slave
  input  wire mstwd_pkg::mstwd_av_req_t       av_req,
  output mstwd_pkg::mstwd_av_rsp_t            av_rsp,
  // power state pin
  input  wire logic                           full_power_state,
  // system outputs
  output logic                                sys_reset_req,
  output logic                                ms_tick,
  output logic [mstwd_pkg::FREQ_W-1:0]        osc_mhz,
  output logic                                wdt_running
);

  // decode helper shared by the bus decoders
  function automatic logic idx_hit(
    input logic [mstwd_pkg::ADDR_W-1:0] addr,
    input logic [mstwd_pkg::IDX_W-1:0]  idx
  );
    idx_hit = (addr[mstwd_pkg::IDX_LSB +: mstwd_pkg::IDX_W] == idx);
  endfunction

  // power state synchroniser
  logic full_power_state_meta_r;
  logic full_power_state_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      full_power_state_meta_r <= 1'b0;
      full_power_state_r      <= 1'b0;
    end else begin
      full_power_state_meta_r <= full_power_state;
      full_power_state_r      <= full_power_state_meta_r;
    end
  end

  // register state
  logic [mstwd_pkg::FREQ_W-1:0] freq_r;
  logic [mstwd_pkg::FREQ_W-1:0] freq_nxt;
  logic [mstwd_pkg::HALF_W-1:0] timeout_r;
  logic [mstwd_pkg::HALF_W-1:0] timeout_nxt;
  logic [mstwd_pkg::HALF_W-1:0] cnt_r;
  logic [mstwd_pkg::HALF_W-1:0] cnt_nxt;
  logic [mstwd_pkg::DATA_W-1:0] key_r;
  logic [mstwd_pkg::DATA_W-1:0] key_nxt;
  logic                         enabled_r;
  logic                         enabled_nxt;
  logic                         expired_r;
  logic                         expired_nxt;
  logic                         nack_r;
  logic                         nack_nxt;

  // bus state
  mstwd_pkg::mstwd_bus_st_t     bus_st_r;
  mstwd_pkg::mstwd_bus_st_t     bus_st_nxt;
  mstwd_pkg::mstwd_av_rsp_t     rsp_r;
  mstwd_pkg::mstwd_av_rsp_t     rsp_nxt;

  // address decode
  wire hit_osc = idx_hit(av_req.address, mstwd_pkg::IDX_OSC_MHZ);
  wire hit_to  = idx_hit(av_req.address, mstwd_pkg::IDX_WDT_TO);
  wire hit_key = idx_hit(av_req.address, mstwd_pkg::IDX_WDT_KEY);
  wire hit_sts = idx_hit(av_req.address, mstwd_pkg::IDX_WDT_STS);
  wire hit_any = hit_osc | hit_to | hit_key | hit_sts;

  // request taken in idle, completed at the following edge
  wire req_new = (av_req.read | av_req.write) && (bus_st_r == mstwd_pkg::BUS_IDLE);
  wire wr_fire = av_req.write && (bus_st_r == mstwd_pkg::BUS_ACK);

  // write data checks
  wire [mstwd_pkg::DATA_W-1:0] wdata = av_req.writedata;
  wire freq_ok = (wdata >= mstwd_pkg::FREQ_MIN) && (wdata <= mstwd_pkg::FREQ_MAX);
  wire to_ok   = (wdata[mstwd_pkg::CNT_LSB +: mstwd_pkg::HALF_W] ==
                  ~wdata[mstwd_pkg::HALF_W-1:0]);

  // committed writes
  wire wr_freq    = wr_fire && hit_osc && freq_ok;
  wire wr_timeout = wr_fire && hit_to && to_ok;
  wire wr_key     = wr_fire && hit_key;
  wire wr_sts     = wr_fire && hit_sts;
  wire key_magic  = (wdata == mstwd_pkg::KEY_MAGIC);
  wire key_enable = (wdata == mstwd_pkg::KEY_ENABLE);
  wire bad_write  = (hit_osc && !freq_ok) || (hit_to && !to_ok);

  // tick generator
  logic tick;

  mstwd_tick_div u_tick_div (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .mhz     (freq_r),
    .tick    (tick)
  );

  // watchdog counting
  wire count_en  = enabled_r && full_power_state_r && !expired_r;
  wire cnt_zero  = (cnt_r == mstwd_pkg::CNT_RST);
  wire cnt_last  = (cnt_r == mstwd_pkg::CNT_ONE);
  wire cnt_step  = count_en && tick && !cnt_zero;
  wire hit_zero  = count_en && (cnt_zero || (tick && cnt_last));

  // next-state for frequency, timeout and key
  assign freq_nxt    = wr_freq ? wdata[mstwd_pkg::FREQ_W-1:0] : freq_r;
  assign timeout_nxt = wr_timeout ? wdata[mstwd_pkg::HALF_W-1:0] : timeout_r;
  assign key_nxt     = wr_key ? wdata : key_r;

  // enable follows the two documented key values; other values only store
  always_comb begin
    enabled_nxt = enabled_r;
    if (wr_key && key_magic) begin
      enabled_nxt = 1'b0;
    end else if (wr_key && key_enable) begin
      enabled_nxt = 1'b1;
    end
  end

  // counter: disable clears, enable or refresh reloads, tick decrements
  always_comb begin
    cnt_nxt = cnt_r;
    if (wr_key && key_magic) begin
      cnt_nxt = mstwd_pkg::CNT_RST;
    end else if (wr_timeout) begin
      cnt_nxt = wdata[mstwd_pkg::HALF_W-1:0];
    end else if (wr_key && key_enable && !enabled_r) begin
      cnt_nxt = timeout_r;
    end else if (cnt_step) begin
      cnt_nxt = cnt_r - mstwd_pkg::CNT_ONE;
    end
  end

  // expiry latches until the system reset it requests arrives
  always_comb begin
    expired_nxt = expired_r;
    if (hit_zero) begin
      expired_nxt = 1'b1;
    end
  end

  // sticky refused-write flag; a new refusal wins over a clear
  always_comb begin
    nack_nxt = nack_r;
    if (wr_sts && wdata[mstwd_pkg::STS_NACK]) begin
      nack_nxt = 1'b0;
    end
    if (wr_fire && bad_write) begin
      nack_nxt = 1'b1;
    end
  end

  // read mux
  logic [mstwd_pkg::DATA_W-1:0] rd_val;

  always_comb begin
    rd_val = '0;
    if (hit_osc) begin
      rd_val[mstwd_pkg::FREQ_W-1:0] = freq_r;
    end else if (hit_to) begin
      rd_val = {cnt_r, timeout_r};
    end else if (hit_key) begin
      rd_val = key_r;
    end else if (hit_sts) begin
      rd_val[mstwd_pkg::STS_EXPIRED] = expired_r;
      rd_val[mstwd_pkg::STS_NACK]    = nack_r;
      rd_val[mstwd_pkg::STS_RUN]     = enabled_r;
      rd_val[mstwd_pkg::STS_FULL_POWER_STATE]   = full_power_state_r;
    end
  end

  // response code
  logic [1:0] rsp_code;

  always_comb begin
    rsp_code = mstwd_pkg::RSP_OKAY;
    if (!hit_any) begin
      rsp_code = mstwd_pkg::RSP_DECERR;
    end else if (av_req.write && bad_write) begin
      rsp_code = mstwd_pkg::RSP_SLVERR;
    end
  end

  // bus sequencing: one wait cycle, answer on the second edge
  always_comb begin
    bus_st_nxt                 = bus_st_r;
    rsp_nxt                    = rsp_r;
    rsp_nxt.waitrequest        = 1'b1;
    rsp_nxt.writeresponsevalid = 1'b0;
    unique case (bus_st_r)
      mstwd_pkg::BUS_IDLE: begin
        if (req_new) begin
          bus_st_nxt                 = mstwd_pkg::BUS_ACK;
          rsp_nxt.waitrequest        = 1'b0;
          rsp_nxt.readdata           = av_req.read ? rd_val : '0;
          rsp_nxt.response           = rsp_code;
          rsp_nxt.writeresponsevalid = av_req.write;
        end
      end
      mstwd_pkg::BUS_ACK: begin
        bus_st_nxt = mstwd_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_st_r                 <= mstwd_pkg::BUS_IDLE;
      rsp_r.waitrequest        <= 1'b1;
      rsp_r.readdata           <= '0;
      rsp_r.response           <= mstwd_pkg::RSP_OKAY;
      rsp_r.writeresponsevalid <= 1'b0;
    end else begin
      bus_st_r <= bus_st_nxt;
      rsp_r    <= rsp_nxt;
    end
  end

  // register and counter flops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      freq_r    <= mstwd_pkg::FREQ_RST;
      timeout_r <= mstwd_pkg::TIMEOUT_RST;
      cnt_r     <= mstwd_pkg::CNT_RST;
      key_r     <= mstwd_pkg::KEY_MAGIC;
      enabled_r <= 1'b0;
      expired_r <= 1'b0;
      nack_r    <= 1'b0;
    end else begin
      freq_r    <= freq_nxt;
      timeout_r <= timeout_nxt;
      cnt_r     <= cnt_nxt;
      key_r     <= key_nxt;
      enabled_r <= enabled_nxt;
      expired_r <= expired_nxt;
      nack_r    <= nack_nxt;
    end
  end

  // registered system outputs
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sys_reset_req <= 1'b0;
      ms_tick       <= 1'b0;
      osc_mhz       <= mstwd_pkg::FREQ_RST;
      wdt_running   <= 1'b0;
    end else begin
      sys_reset_req <= expired_nxt;
      ms_tick       <= tick;
      osc_mhz       <= freq_nxt;
      wdt_running   <= enabled_nxt && !expired_nxt;
    end
  end

  assign av_rsp = rsp_r;

endmodule
